// ### rtl/encd_pkg.sv
// constants for the encoder diagnostic reply and position wrap block
package encd_pkg;
    localparam int         DIAG_LEN     = 16;
    localparam logic [3:0] IDX_LAST     = 4'hF;
    localparam logic [3:0] IDX_MADDR    = 4'h3;
    localparam logic [3:0] IDX_ID_HI    = 4'h4;
    localparam logic [3:0] IDX_ID_LO    = 4'h5;
    localparam logic [3:0] IDX_EXT_HDR  = 4'h6;
    localparam logic [3:0] IDX_ALARM    = 4'h7;
    localparam logic [3:0] IDX_OPER     = 4'h8;
    localparam logic [3:0] IDX_TYPE     = 4'h9;
    localparam logic [3:0] IDX_RES_B3   = 4'hA;
    localparam logic [3:0] IDX_RES_B2   = 4'hB;
    localparam logic [3:0] IDX_RES_B1   = 4'hC;
    localparam logic [3:0] IDX_RES_B0   = 4'hD;
    localparam logic [3:0] IDX_REV_HI   = 4'hE;
    localparam logic [3:0] IDX_REV_LO   = 4'hF;
    localparam logic [7:0] EXT_HDR_LEN  = 8'h0A;
    localparam logic [7:0] ALARM_NONE   = 8'h00;
    localparam logic [7:0] TYPE_MULTI   = 8'h01;
    localparam int         OP_DIR       = 0;
    localparam int         OP_EXT       = 1;
    localparam int         OP_SCALE     = 3;
    localparam int         OP_XCHG      = 7;
    localparam logic [7:0] OP_USED_MASK = 8'h8B;
    localparam logic [7:0] OP_DEFAULT   = 8'h0A;
    localparam logic [7:0] MADDR_NONE   = 8'hFF;
    typedef enum logic [0:0] {TX_IDLE = 1'b0, TX_SEND = 1'b1} encd_tx_type;
    typedef enum logic [1:0] {CF_INIT = 2'b00, CF_IDLE = 2'b01, CF_CALC = 2'b10} encd_cf_type;
endpackage : encd_pkg

// ### rtl/encd_diag.sv
// encoder diagnostic reply builder, configuration defaults and red-zone position wrap
`timescale 1ns/10ps
`default_nettype none
// Operation
// - reply is sixteen bytes, standard then extended
// - byte 3 is parametrizing master address
// - bytes 4 and 5 carry maker identifier
// - byte 6 is extended length, ten
// - byte 7 alarms always zero
// - byte 8 echoes operating parameter byte
// - status bit 0 is count direction
// - bit 1 extended class, bit 3 scaling
// - bit 7 position plus velocity selection
// - bits 2 and 4 to 6 zero
// - byte 9 type code one, multiturn
// - bytes 10 to 13 steps per revolution
// - bytes 14 and 15 revolution count
// - remainder found by repeated span subtraction
// - position jumps entering or leaving remainder
// - remainder region ends at span minus one
// - extended class enabled by default
// - default payload follows velocity class strap
module encd_diag
    import encd_pkg::*;
#(
    parameter logic [15:0] IDENT_CODE = 16'h0ABC,        // arbitrary value
    parameter logic [31:0] ST_RES     = 32'h0001_0000,   // physical steps per revolution
    parameter logic [15:0] REV_COUNT  = 16'h4000,        // distinguishable revolutions
    parameter logic [31:0] HW_TOTAL   = 32'h4000_0000    // native total span
) (
    input  wire logic        mclk,          // system clock
    input  wire logic        rstn,          // async reset, active low
    input  wire logic        clk_en,        // clock enable, freezes all state except the reset synchronizer when low
    input  wire logic        vel_class,     // strap: velocity-extended class in use
    input  wire logic [7:0]  stat_byte0,    // standard station status byte 0
    input  wire logic [7:0]  stat_byte1,    // standard station status byte 1
    input  wire logic [7:0]  stat_byte2,    // standard station status byte 2
    input  wire logic        prm_write,     // parameter_set_service pulse
    input  wire logic [7:0]  prm_maddr,     // address of the parametrizing master
    input  wire logic [7:0]  prm_oper,      // operating parameter byte
    input  wire logic [31:0] prm_span,      // configured total span
    input  wire logic        diag_req,      // diagnostic_request_service pulse
    input  wire logic [31:0] raw_pos,       // native position
    output logic             diag_valid,    // reply byte valid
    output logic [7:0]       diag_byte,     // reply byte
    output logic [3:0]       diag_index,    // reply byte number
    output logic             diag_last,     // last reply byte
    output logic [7:0]       oper_status,   // current operating status
    output logic [7:0]       master_addr,   // current parametrizing master
    output logic             calc_busy,     // remainder calculation running
    output logic [31:0]      pos_out,       // reported position
    output logic             red_zone       // position inside remainder region
);

    ////////////////////////////////////////////////////////////////////////
    // reset release
    logic       rst_meta_reg;
    logic       rst_sync_reg;
    wire  logic rst_n = rst_sync_reg;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // configuration and remainder calculation
    encd_cf_type cf_reg;
    logic [7:0]  oper_reg;
    logic [7:0]  maddr_reg;
    logic [31:0] span_reg;
    logic [31:0] rem_reg;
    logic [31:0] full_reg;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cf_reg    <= CF_INIT;
            oper_reg  <= OP_DEFAULT;
            maddr_reg <= MADDR_NONE;
            span_reg  <= HW_TOTAL;
            rem_reg   <= 32'h0000_0000;
            full_reg  <= HW_TOTAL;
        end else if (clk_en) begin
            case (cf_reg)
                CF_INIT: begin
                    oper_reg         <= OP_DEFAULT;
                    oper_reg[OP_XCHG] <= vel_class;
                    cf_reg           <= CF_IDLE;
                end
                CF_IDLE: begin
                    if (prm_write) begin
                        oper_reg  <= prm_oper & OP_USED_MASK;
                        maddr_reg <= prm_maddr;
                        span_reg  <= (prm_span == 32'h0000_0000) ? HW_TOTAL : prm_span;
                        rem_reg   <= HW_TOTAL;
                        cf_reg    <= CF_CALC;
                    end
                end
                CF_CALC: begin
                    if (rem_reg >= span_reg) begin
                        rem_reg <= rem_reg - span_reg;
                    end else begin
                        full_reg <= HW_TOTAL - rem_reg;
                        cf_reg   <= CF_IDLE;
                    end
                end
                default: cf_reg <= CF_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            oper_status <= OP_DEFAULT;
            master_addr <= MADDR_NONE;
            calc_busy   <= 1'b0;
        end else if (clk_en) begin
            oper_status <= oper_reg;
            master_addr <= maddr_reg;
            calc_busy   <= (cf_reg == CF_CALC);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // position wrap
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pos_out  <= 32'h0000_0000;
            red_zone <= 1'b0;
        end else if (clk_en) begin
            if (!oper_reg[OP_SCALE]) begin
                pos_out  <= raw_pos;
                red_zone <= 1'b0;
            end else if (raw_pos >= full_reg) begin
                // last native step maps to span minus one
                pos_out  <= raw_pos - (HW_TOTAL - span_reg);
                red_zone <= 1'b1;
            end else begin
                pos_out  <= raw_pos % span_reg;
                red_zone <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // diagnostic reply
    function automatic logic [7:0] msg_byte(input logic [3:0] idx, input logic [7:0] s0, input logic [7:0] s1,
                                            input logic [7:0] s2, input logic [7:0] ma, input logic [7:0] op);
        case (idx)
            4'h0:        msg_byte = s0;
            4'h1:        msg_byte = s1;
            4'h2:        msg_byte = s2;
            IDX_MADDR:   msg_byte = ma;
            IDX_ID_HI:   msg_byte = IDENT_CODE[15:8];
            IDX_ID_LO:   msg_byte = IDENT_CODE[7:0];
            IDX_EXT_HDR: msg_byte = EXT_HDR_LEN;
            IDX_ALARM:   msg_byte = ALARM_NONE;
            IDX_OPER:    msg_byte = op;
            IDX_TYPE:    msg_byte = TYPE_MULTI;
            IDX_RES_B3:  msg_byte = ST_RES[31:24];
            IDX_RES_B2:  msg_byte = ST_RES[23:16];
            IDX_RES_B1:  msg_byte = ST_RES[15:8];
            IDX_RES_B0:  msg_byte = ST_RES[7:0];
            IDX_REV_HI:  msg_byte = REV_COUNT[15:8];
            default:     msg_byte = REV_COUNT[7:0];
        endcase
    endfunction : msg_byte

    encd_tx_type tx_reg;
    logic [7:0]  snap_reg [DIAG_LEN];
    logic [3:0]  cnt_reg;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tx_reg  <= TX_IDLE;
            cnt_reg <= 4'h0;
            for (int i = 0; i < DIAG_LEN; i++) begin
                snap_reg[i] <= 8'h00;
            end
        end else if (clk_en) begin
            case (tx_reg)
                TX_IDLE: begin
                    if (diag_req) begin
                        for (int i = 0; i < DIAG_LEN; i++) begin
                            snap_reg[i] <= msg_byte(4'(i), stat_byte0, stat_byte1, stat_byte2, maddr_reg, oper_reg);
                        end
                        cnt_reg <= 4'h0;
                        tx_reg  <= TX_SEND;
                    end
                end
                TX_SEND: begin
                    if (cnt_reg == IDX_LAST) begin
                        tx_reg <= TX_IDLE;
                    end
                    cnt_reg <= cnt_reg + 4'h1;
                end
                default: tx_reg <= TX_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            diag_valid <= 1'b0;
            diag_byte  <= 8'h00;
            diag_index <= 4'h0;
            diag_last  <= 1'b0;
        end else if (clk_en) begin
            diag_valid <= (tx_reg == TX_SEND);
            diag_byte  <= snap_reg[cnt_reg];
            diag_index <= cnt_reg;
            diag_last  <= (tx_reg == TX_SEND) && (cnt_reg == IDX_LAST);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    a_reply_start: assert property (clk_en && tx_reg == TX_IDLE && diag_req ##1 clk_en
                                    |=> diag_valid && diag_index == 4'h0)
        else $error("reply does not start at byte zero");
    a_reply_order: assert property (clk_en && diag_valid && !diag_last
                                    |=> diag_valid && diag_index == $past(diag_index) + 4'h1)
        else $error("reply bytes not consecutive");
    a_last_flag: assert property (diag_last |-> diag_valid && diag_index == IDX_LAST)
        else $error("last flag not on byte fifteen");
    a_send_hold: assert property (clk_en && tx_reg == TX_SEND && cnt_reg != IDX_LAST
                                  |=> tx_reg == TX_SEND)
        else $error("reply cut short");
    a_master_byte: assert property (diag_valid && diag_index == IDX_MADDR |-> diag_byte == snap_reg[IDX_MADDR])
        else $error("master address byte wrong");
    a_ident_bytes: assert property (diag_valid && diag_index == IDX_ID_LO |->
                                    diag_byte == IDENT_CODE[7:0] && $past(diag_byte) == IDENT_CODE[15:8])
        else $error("ident bytes wrong");
    a_ext_header: assert property (diag_valid && diag_index == IDX_EXT_HDR |-> diag_byte == EXT_HDR_LEN)
        else $error("extended header not ten");
    a_alarm_zero: assert property (diag_valid && diag_index == IDX_ALARM |-> diag_byte == ALARM_NONE)
        else $error("alarm byte not zero");
    a_oper_echo: assert property (clk_en && cf_reg == CF_IDLE && prm_write |=> oper_reg == ($past(prm_oper) & OP_USED_MASK))
        else $error("operating byte not echoed");
    a_unused_zero: assert property ((oper_status & ~OP_USED_MASK) == 8'h00)
        else $error("unused status bits set");
    a_type_code: assert property (diag_valid && diag_index == IDX_TYPE |-> diag_byte == TYPE_MULTI)
        else $error("encoder type wrong");
    a_res_msb: assert property (diag_valid && diag_index == IDX_RES_B0 |-> diag_byte == ST_RES[7:0] &&
                                $past(diag_byte, 3) == ST_RES[31:24])
        else $error("resolution bytes wrong");
    a_rev_bytes: assert property (diag_valid && diag_index == IDX_REV_LO |-> diag_byte == REV_COUNT[7:0])
        else $error("revolution bytes wrong");
    a_rem_bound: assert property (cf_reg == CF_CALC ##1 cf_reg == CF_IDLE |-> rem_reg < span_reg)
        else $error("remainder not below span");

    // position, status and default checks
    a_zone_top: assert property (clk_en && oper_reg[OP_SCALE] && cf_reg == CF_IDLE && !prm_write
                                 && raw_pos == HW_TOTAL - 32'h1
                                 |=> pos_out == span_reg - 32'h1 && red_zone == (full_reg != HW_TOTAL))
        else $error("red zone end not span minus one");
    a_zone_jump: assert property (clk_en && oper_reg[OP_SCALE] && cf_reg == CF_IDLE && !prm_write
                                  && full_reg != HW_TOTAL && raw_pos == full_reg
                                  |=> red_zone && pos_out == span_reg - (HW_TOTAL - full_reg))
        else $error("no jump on entry to red zone");
    a_zone_leave: assert property (clk_en && oper_reg[OP_SCALE] && cf_reg == CF_IDLE && !prm_write
                                   && full_reg != 32'h0 && raw_pos == full_reg - 32'h1
                                   |=> !red_zone && pos_out == span_reg - 32'h1)
        else $error("last full section does not end at span minus one");
    a_no_scale: assert property (clk_en && !oper_reg[OP_SCALE]
                                 |=> pos_out == $past(raw_pos) && !red_zone)
        else $error("unscaled position altered");
    a_status_follow: assert property (clk_en |=> oper_status == $past(oper_reg))
        else $error("operating status not following configuration");
    a_calc_flag: assert property (clk_en |=> calc_busy == ($past(cf_reg) == CF_CALC))
        else $error("busy flag not following calculation");
    a_default_ext: assert property ($rose(rst_n) |-> oper_reg[OP_EXT] && oper_reg[OP_SCALE])
        else $error("default extended class off");
    a_default_pay: assert property (clk_en && rst_n && cf_reg == CF_INIT
                                    |=> oper_reg[OP_XCHG] == $past(vel_class) && oper_reg[OP_EXT])
        else $error("default payload not from strap");

endmodule : encd_diag
`default_nettype wire

// ### sim/encd_master.sv
// bus master model that parametrizes the encoder and asks for diagnostics
`timescale 1ns/10ps
`default_nettype none
module encd_master (
    input  wire logic        mclk,        // system clock
    input  wire logic        diag_valid,  // reply byte valid
    input  wire logic [7:0]  diag_byte,   // reply byte
    input  wire logic [3:0]  diag_index,  // reply byte number
    input  wire logic        diag_last,   // last reply byte
    output var  logic        diag_req,    // diagnostic request pulse
    output var  logic        prm_write,   // parameter set pulse
    output var  logic [7:0]  prm_maddr,   // our bus address
    output var  logic [7:0]  prm_oper,    // operating byte
    output var  logic [31:0] prm_span     // configured total span
);
    logic [11:0] rxq[$];
    initial begin
        diag_req  = 1'b0;
        prm_write = 1'b0;
        prm_maddr = 8'h00;
        prm_oper  = 8'h00;
        prm_span  = 32'h0000_0000;
    end
    // requests at start, on the last byte for back to back, and at byte five mid-reply
    task automatic do_diag(input int n, input bit poke);
        int left;
        int w;
        left = n;
        w = 0;
        rxq.delete();
        @(posedge mclk);
        #1 diag_req = 1'b1;
        while (left > 0 && w < 200) begin
            @(posedge mclk);
            #1;
            w++;
            if (diag_valid === 1'b1) rxq.push_back({diag_index, diag_byte});
            // follow-on request rides on the last byte, taken once the reply is over
            diag_req = (w < 200) && (diag_valid === 1'b1) &&
                       ((diag_last === 1'b1 && left > 1) || (diag_index == 4'h5 && poke));
            if (diag_valid === 1'b1 && diag_last === 1'b1) left--;
        end
    endtask : do_diag
    task automatic do_prm(input logic [7:0] ma, input logic [7:0] op, input logic [31:0] sp);
        @(posedge mclk);
        #1;
        prm_write = 1'b1;
        prm_maddr = ma;
        prm_oper  = op;
        prm_span  = sp;
        @(posedge mclk);
        #1;
        prm_write = 1'b0;
        prm_maddr = ~ma;
        prm_oper  = ~op;
        prm_span  = ~sp;
    endtask : do_prm
endmodule : encd_master
`default_nettype wire

// ### sim/tb_encd_diag.sv
// self-checking bench for the encoder diagnostic reply and position wrap block
`timescale 1ns/10ps
`default_nettype none
module tb_encd_diag;
    localparam logic [15:0] IDC  = 16'h2C5E;  // arbitrary value
    localparam logic [31:0] STR  = 32'h0001_0000;
    localparam logic [15:0] REVC = 16'h4000;
    localparam longint      HWT  = 4096;
    logic        mclk, rstn, clk_en, vel_class, prm_write, diag_req, diag_valid, diag_last, calc_busy, red_zone;
    logic [7:0]  st0, st1, st2, prm_maddr, prm_oper, diag_byte, oper_status, master_addr;
    logic [31:0] prm_span, raw_pos, pos_out;
    logic [3:0]  diag_index;
    int          errors, total_checks, cycles;
    logic [7:0]  m_addr, m_oper;
    longint      m_span;
    encd_diag #(.IDENT_CODE(IDC), .ST_RES(STR), .REV_COUNT(REVC), .HW_TOTAL(32'h0000_1000)) dut (
        .mclk(mclk), .rstn(rstn), .clk_en(clk_en), .vel_class(vel_class), .stat_byte0(st0),
        .stat_byte1(st1), .stat_byte2(st2), .prm_write(prm_write), .prm_maddr(prm_maddr),
        .prm_oper(prm_oper), .prm_span(prm_span), .diag_req(diag_req), .raw_pos(raw_pos),
        .diag_valid(diag_valid), .diag_byte(diag_byte), .diag_index(diag_index), .diag_last(diag_last),
        .oper_status(oper_status), .master_addr(master_addr), .calc_busy(calc_busy),
        .pos_out(pos_out), .red_zone(red_zone));
    encd_master u_m (.mclk(mclk), .diag_valid(diag_valid), .diag_byte(diag_byte), .diag_index(diag_index),
        .diag_last(diag_last), .diag_req(diag_req), .prm_write(prm_write), .prm_maddr(prm_maddr),
        .prm_oper(prm_oper), .prm_span(prm_span));
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            finish_test();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check
    task automatic finish_test();
        $display("checks %0d, errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : finish_test
    ////////////////////////////////////////////////////////////////////////////////
    task automatic do_reset(input logic vel);
        rstn = 1'b0;
        vel_class = vel;
        repeat (20) @(posedge mclk);
        #1 rstn = 1'b1;
        repeat (5) @(posedge mclk);
        #1;
        m_oper = 8'h0A | {vel, 7'h00};
        m_addr = 8'hFF;
        m_span = HWT;
        check(oper_status, m_oper, "default operating byte");
        check(master_addr, 8'hFF, "default master address");
    endtask : do_reset
    function automatic logic [7:0] expb(input int k);
        case (k)
            0: return st0;
            1: return st1;
            2: return st2;
            3: return m_addr;
            4: return IDC[15:8];
            5: return IDC[7:0];
            6: return 8'h0A;
            7: return 8'h00;
            8: return m_oper;
            9: return 8'h01;
            14: return REVC[15:8];
            15: return REVC[7:0];
            default: return STR[8*(13-k) +: 8];
        endcase
    endfunction : expb
    task automatic check_diag(input int n, input bit poke);
        st0 = 8'($urandom);
        st1 = 8'($urandom);
        st2 = 8'($urandom);
        u_m.do_diag(n, poke);
        check(32'(u_m.rxq.size()), 32'(16 * n), "reply length");
        for (int i = 0; i < u_m.rxq.size(); i++) begin
            check(u_m.rxq[i], {4'(i % 16), expb(i % 16)}, "reply byte");
        end
        repeat (2) @(posedge mclk);
        #1;
        check(diag_valid, 1'b0, "reply ends");
    endtask : check_diag
    task automatic pos_run();
        longint r, rem, ex;
        logic   rz;
        rem = HWT % m_span;
        for (int j = 0; j < 24; j++) begin
            r = (j < 3) ? (HWT - rem - 1 + j) % HWT : (j == 3) ? HWT - 1 : longint'($urandom % HWT);
            raw_pos = 32'(r);
            @(posedge mclk);
            #1;
            rz = m_oper[3] && r >= HWT - rem;
            ex = !m_oper[3] ? r : (rz ? r - (HWT - m_span) : r % m_span);
            check(pos_out, 32'(ex), "reported position");
            check(red_zone, rz, "remainder flag");
        end
    endtask : pos_run
    task automatic prm(input logic [7:0] op, input logic [31:0] sp);
        int w;
        m_addr = 8'($urandom);
        u_m.do_prm(m_addr, op, sp);
        m_oper = op & 8'h8B;
        m_span = (sp == 0) ? HWT : longint'(sp);
        @(posedge mclk);
        #1;
        check(calc_busy, 1'b1, "calculation running");
        repeat (2) @(posedge mclk);
        #1;
        w = 0;
        while (calc_busy !== 1'b0 && w < 2000) begin
            @(posedge mclk);
            #1;
            w++;
        end
        check(calc_busy, 1'b0, "calculation ends");
        @(posedge mclk);
        #1;
        check(oper_status, m_oper, "operating status");
        check(master_addr, m_addr, "master address");
    endtask : prm
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] spans[3];
        errors = 0;
        total_checks = 0;
        cycles = 0;
        spans = '{32'd1000, 32'd1024, 32'd0};
        clk_en = 1'b1;
        raw_pos = 32'h0000_0000;
        {st0, st1, st2} = 24'h00_0000;
        void'($urandom(32'h7500));
        do_reset(1'b0);
        check_diag(1, 1'b0);
        pos_run();
        for (int c = 0; c < 3; c++) begin
            prm(8'($urandom) | (c < 2 ? 8'h08 : 8'h00), spans[c]);
            pos_run();
            check_diag(2, c[0]);
        end
        prm(8'hFF, 32'd700);
        pos_run();
        do_reset(1'b1);
        check_diag(1, 1'b1);
        finish_test();
    end
endmodule : tb_encd_diag
`default_nettype wire
